// [inc/sscr_consts.svh]
// register offsets, field positions, reset values and timing counts of the supply/clock bank
`ifndef SSCR_CONSTS_SVH
`define SSCR_CONSTS_SVH
`define SSCR_OFF_SYNC        12'h030
`define SSCR_OFF_SUPMON      12'h034
`define SSCR_OFF_REG         12'h03c
`define SSCR_OFF_REF         12'h040
`define SSCR_OFF_PLLA        12'h044
`define SSCR_OFF_STATUS      12'h048
`define SSCR_B_VALUE_READ_REQUEST       7
`define SSCR_B_LEVEL_HI      21
`define SSCR_B_LEVEL_LO      16
`define SSCR_B_PSEL_HI       15
`define SSCR_B_PSEL_LO       12
`define SSCR_B_CEN           9
`define SSCR_B_MODE          8
`define SSCR_B_RUNSTBY       6
`define SSCR_B_ACT_HI        4
`define SSCR_B_ACT_LO        3
`define SSCR_B_HYSTERESIS_ENABLE          2
`define SSCR_B_EN            1
`define SSCR_B_FORCE         13
`define SSCR_B_CAL_HI        26
`define SSCR_B_CAL_LO        16
`define SSCR_B_BGOUT         2
`define SSCR_B_TEMP_SENSOR_ENABLE          1
`define SSCR_B_ONREQ         7
`define SSCR_ACT_RESET       2'h1
`define SSCR_ACT_IRQ         2'h2
`define SSCR_PLLA_RESET      8'h80
`define SSCR_ULP_HZ          32000
`define SSCR_CLK_HZ          25000000
`define SSCR_ULP_DIV         (`SSCR_CLK_HZ / `SSCR_ULP_HZ)
`define SSCR_TICK_1K         32
`define SSCR_SYNC_CYC        4'h4
`define SSCR_PLL_CYC         4'h8
`define SSCR_CEN_CYC         4'h3
`endif

// [inc/sscr_pkg.sv]
// types of the supply/clock control bank
package sscr_pkg;
   typedef enum logic [1:0] {
      SSCR_VAL_IDLE = 2'b00,
      SSCR_VAL_WAIT = 2'b01,
      SSCR_VAL_DONE = 2'b10
   } sscr_val_state_type;
   typedef struct packed {
      logic [5:0]         level;
      logic [3:0]         psel;
      logic               sampling_clock_enable;
      logic               cen_run;
      logic [3:0]         cen_cnt;
      logic               mode;
      logic               mon_stby;
      logic [1:0]         action;
      logic               hysteresis_enable;
      logic               mon_en;
      logic               force_drv;
      logic               reg_stby;
      logic [10:0]        bandgap_calibration;
      logic               bgout;
      logic               temp_sensor_enable;
      logic               pll_onreq;
      logic               pll_stby;
      logic               pll_en;
      logic               pll_stat;
      logic [3:0]         pll_cnt;
      logic [3:0]         sync_cnt;
      sscr_val_state_type vstate;
      logic [31:0]        val;
      logic               ready;
      logic [9:0]         ulp_cnt;
      logic               ulp_1k;
      logic [4:0]         div1k;
      logic [15:0]        pre_cnt;
      logic               sample;
      logic               bod_reset;
      logic               bod_irq;
      logic               loaded;
      logic               mon_act;
      logic               pll_run;
      logic               busy;
      logic               pready;
      logic [31:0]        prdata;
   } sscr_state_type;
endpackage

// [design/sscr_top.sv]
// supply monitor, regulator, reference and pll control register bank on apb
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "sscr_consts.svh"

// Behaviour
// - refresh value register then raise ready flag
// - monitor fields load from user row
// - prescaler divides by two to field plus one
// - prescaler fed by 1kHz oscillator tick
// - clock enable bit starts or stops sampling
// - clock enable reads back stable run state
// - mode bit selects continuous or sampled
// - monitor standby bit keeps monitor in standby
// - action field selects none, reset, interrupt
// - hysteresis bit drives threshold hysteresis
// - force bit selects high drive in standby
// - regulator standby bit keeps normal configuration
// - calibration loads from row, stays writable
// - bandgap output enable routes to converter
// - sensor enable powers and routes sensor
// - pll control resets 0x80, on-request gating
// - pll standby bit keeps loop in standby
// - pll enabled status follows after delay
module sscr_top
   import sscr_pkg::*;
(
   input  wire logic        clk_i,          // system clock, 25 MHz
   input  wire logic        rst_n_i,        // async reset, active low
   input  wire logic        psel_i,         // apb select
   input  wire logic        penable_i,      // apb access phase
   input  wire logic        pwrite_i,       // apb direction
   input  wire logic [11:0] paddr_i,        // apb byte address
   input  wire logic [31:0] pwdata_i,       // apb write data
   output logic             pready_o,       // apb ready
   output logic [31:0]      prdata_o,       // apb read data
   output logic             pslverr_o,      // apb error, tied low, unmapped offsets not flagged
   input  wire logic        start_load_i,   // one pulse: row data valid
   input  wire logic [10:0] user_row_i,     // level,action,hysteresis_enable,enable
   input  wire logic [10:0] bandgap_calibration_row_i,    // bandgap calibration
   input  wire logic [31:0] loop_live_i,    // live loop value
   input  wire logic        standby_i,      // standby sleep active
   input  wire logic        supply_low_i,   // supply below threshold
   input  wire logic        periph_req_i,   // peripheral wants pll
   output logic             loop_ready_o,   // loop ready flag
   output logic [31:0]      loop_value_o,   // loop value register
   output logic [5:0]       mon_level_o,    // threshold level
   output logic             mon_active_o,   // monitor running now
   output logic             mon_sampled_o,  // sampled mode in use
   output logic             mon_sample_o,   // sampling strobe
   output logic             mon_hysteresis_enable_o,     // threshold hysteresis
   output logic             mon_reset_o,    // reset request
   output logic             mon_irq_o,      // interrupt request
   output logic             reg_high_drv_o, // regulator high drive
   output logic             reg_normal_o,   // regulator normal in standby
   output logic [10:0]      bg_bandgap_calibration_o,     // bandgap trim
   output logic             bg_route_o,     // bandgap to converter
   output logic             ts_enable_o,    // temperature sensor on
   output logic             pll_run_o,      // pll oscillator running
   output logic             mon_sync_busy_o // monitor sync pending
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   sscr_state_type s_reg;
   sscr_state_type s_next;
   logic           wr;
   logic           rd;
   logic           mapped;
   logic [31:0]    rdv;

   // prescaler terminal count: 2^(psel+1) ticks
   function automatic logic [15:0] pre_top(input logic [3:0] sel);
      pre_top = 16'(17'h00002 << sel) - 16'h0001;
   endfunction

   // decode of mapped offsets
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `SSCR_OFF_SYNC) || (a == `SSCR_OFF_SUPMON) ||
                  (a == `SSCR_OFF_REG)  || (a == `SSCR_OFF_REF)   ||
                  (a == `SSCR_OFF_PLLA) || (a == `SSCR_OFF_STATUS);
   endfunction

   assign wr     = psel_i && penable_i && pwrite_i && !s_reg.pready;
   assign rd     = psel_i && penable_i && !pwrite_i && !s_reg.pready;
   assign mapped = is_mapped(paddr_i);

   //------------------------------------------------------------
   // read mux
   //------------------------------------------------------------
   always_comb begin
      rdv = 32'h00000000;
      unique case (paddr_i)
         `SSCR_OFF_SUPMON: begin
            rdv[`SSCR_B_LEVEL_HI:`SSCR_B_LEVEL_LO] = s_reg.level;
            rdv[`SSCR_B_PSEL_HI:`SSCR_B_PSEL_LO]   = s_reg.psel;
            rdv[`SSCR_B_CEN]                       = s_reg.cen_run;
            rdv[`SSCR_B_MODE]                      = s_reg.mode;
            rdv[`SSCR_B_RUNSTBY]                   = s_reg.mon_stby;
            rdv[`SSCR_B_ACT_HI:`SSCR_B_ACT_LO]     = s_reg.action;
            rdv[`SSCR_B_HYSTERESIS_ENABLE]                      = s_reg.hysteresis_enable;
            rdv[`SSCR_B_EN]                        = s_reg.mon_en;
         end
         `SSCR_OFF_REG: begin
            rdv[`SSCR_B_FORCE]   = s_reg.force_drv;
            rdv[`SSCR_B_RUNSTBY] = s_reg.reg_stby;
         end
         `SSCR_OFF_REF: begin
            rdv[`SSCR_B_CAL_HI:`SSCR_B_CAL_LO] = s_reg.bandgap_calibration;
            rdv[`SSCR_B_BGOUT]                 = s_reg.bgout;
            rdv[`SSCR_B_TEMP_SENSOR_ENABLE]                  = s_reg.temp_sensor_enable;
         end
         `SSCR_OFF_PLLA: begin
            rdv[`SSCR_B_ONREQ]   = s_reg.pll_onreq;
            rdv[`SSCR_B_RUNSTBY] = s_reg.pll_stby;
            rdv[`SSCR_B_EN]      = s_reg.pll_en;
         end
         `SSCR_OFF_STATUS: begin
            // bit0 loop ready, bit1 monitor sync busy, bit2 pll enabled
            rdv[0] = s_reg.ready;
            rdv[1] = (s_reg.sync_cnt != 4'h0);
            rdv[2] = s_reg.pll_stat;
         end
         default: rdv = 32'h00000000;
      endcase
   end

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      s_next        = s_reg;
      s_next.pready = psel_i && penable_i && !s_reg.pready;
      if (rd) begin
         s_next.prdata = mapped ? rdv : 32'h00000000; // unmapped reads return zero
      end
      // start-up load from nonvolatile rows
      if (start_load_i && !s_reg.loaded) begin
         s_next.loaded = 1'b1;
         s_next.level  = user_row_i[10:5];
         s_next.action = user_row_i[4:3];
         s_next.hysteresis_enable   = user_row_i[2];
         s_next.mon_en = user_row_i[1];
         s_next.bandgap_calibration  = bandgap_calibration_row_i;
      end
      if (wr) begin
         unique case (paddr_i)
            `SSCR_OFF_SYNC: begin
               if (pwdata_i[`SSCR_B_VALUE_READ_REQUEST]) begin
                  s_next.vstate = SSCR_VAL_WAIT;
                  s_next.ready  = 1'b0;
               end
            end
            `SSCR_OFF_SUPMON: begin
               s_next.level    = pwdata_i[`SSCR_B_LEVEL_HI:`SSCR_B_LEVEL_LO];
               s_next.psel     = pwdata_i[`SSCR_B_PSEL_HI:`SSCR_B_PSEL_LO];
               s_next.sampling_clock_enable      = pwdata_i[`SSCR_B_CEN];
               s_next.mode     = pwdata_i[`SSCR_B_MODE];
               s_next.mon_stby = pwdata_i[`SSCR_B_RUNSTBY];
               s_next.action   = pwdata_i[`SSCR_B_ACT_HI:`SSCR_B_ACT_LO];
               s_next.hysteresis_enable     = pwdata_i[`SSCR_B_HYSTERESIS_ENABLE];
               s_next.mon_en   = pwdata_i[`SSCR_B_EN];
               s_next.sync_cnt = `SSCR_SYNC_CYC;
            end
            `SSCR_OFF_REG: begin
               s_next.force_drv = pwdata_i[`SSCR_B_FORCE];
               s_next.reg_stby  = pwdata_i[`SSCR_B_RUNSTBY];
            end
            `SSCR_OFF_REF: begin
               s_next.bandgap_calibration = pwdata_i[`SSCR_B_CAL_HI:`SSCR_B_CAL_LO];
               s_next.bgout = pwdata_i[`SSCR_B_BGOUT];
               s_next.temp_sensor_enable  = pwdata_i[`SSCR_B_TEMP_SENSOR_ENABLE];
            end
            `SSCR_OFF_PLLA: begin
               s_next.pll_onreq = pwdata_i[`SSCR_B_ONREQ];
               s_next.pll_stby  = pwdata_i[`SSCR_B_RUNSTBY];
               s_next.pll_en    = pwdata_i[`SSCR_B_EN];
               if (pwdata_i[`SSCR_B_EN] != s_reg.pll_stat) begin
                  s_next.pll_cnt = `SSCR_PLL_CYC;
               end
            end
            default: s_next.pready = s_reg.pready | s_next.pready;
         endcase
      end
      // monitor write synchronisation countdown
      if (s_reg.sync_cnt != 4'h0 && !(wr && paddr_i == `SSCR_OFF_SUPMON)) begin
         s_next.sync_cnt = s_reg.sync_cnt - 4'h1;
      end
      // loop value refresh handshake
      unique case (s_reg.vstate)
         SSCR_VAL_IDLE: ;
         SSCR_VAL_WAIT: begin
            s_next.val    = loop_live_i;
            s_next.vstate = SSCR_VAL_DONE;
         end
         SSCR_VAL_DONE: begin
            s_next.ready  = 1'b1;
            s_next.vstate = SSCR_VAL_IDLE;
         end
         default: s_next.vstate = SSCR_VAL_IDLE;
      endcase
      // 1kHz tick from the low power oscillator model
      s_next.ulp_1k = 1'b0;
      if (s_reg.ulp_cnt == 10'(`SSCR_ULP_DIV - 1)) begin
         s_next.ulp_cnt = 10'h000;
         s_next.div1k   = s_reg.div1k + 5'h01;
         s_next.ulp_1k  = (s_reg.div1k == 5'(`SSCR_TICK_1K - 1));
      end else begin
         s_next.ulp_cnt = s_reg.ulp_cnt + 10'h001;
      end
      // sampling clock enable status with start/stop latency
      if (s_reg.sampling_clock_enable != s_reg.cen_run) begin
         if (s_reg.cen_cnt == `SSCR_CEN_CYC) begin
            s_next.cen_run = s_reg.sampling_clock_enable;
            s_next.cen_cnt = 4'h0;
         end else begin
            s_next.cen_cnt = s_reg.cen_cnt + 4'h1;
         end
      end else begin
         s_next.cen_cnt = 4'h0;
      end
      // prescaler for sampled mode
      s_next.sample = 1'b0;
      if (s_reg.cen_run && s_reg.ulp_1k) begin
         if (s_reg.pre_cnt >= pre_top(s_reg.psel)) begin
            s_next.pre_cnt = 16'h0000;
            s_next.sample  = 1'b1;
         end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 16'h0001;
         end
      end
      // brown-out action
      s_next.bod_reset = mon_active_o && supply_low_i &&
                         (s_reg.action == `SSCR_ACT_RESET);
      s_next.bod_irq   = mon_active_o && supply_low_i &&
                         (s_reg.action == `SSCR_ACT_IRQ);
      // pll enable status follows control after a delay
      if (s_reg.pll_cnt != 4'h0) begin
         s_next.pll_cnt = s_reg.pll_cnt - 4'h1;
         if (s_reg.pll_cnt == 4'h1) begin
            s_next.pll_stat = s_reg.pll_en;
         end
      end
      // gated enables kept in state so that the outputs leave flip-flops
      s_next.mon_act = s_next.mon_en && (!standby_i || s_next.mon_stby);
      s_next.pll_run = s_next.pll_stat && (!standby_i || s_next.pll_stby) &&
                       (!s_next.pll_onreq || periph_req_i);
      s_next.busy    = (s_next.sync_cnt != 4'h0);
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg           <= '0;
         s_reg.pll_onreq <= 1'(`SSCR_PLLA_RESET >> `SSCR_B_ONREQ);
      end else begin
         s_reg <= s_next;
      end
   end

   //------------------------------------------------------------
   // outputs, all registered except pslverr_o, tied low
   //------------------------------------------------------------

   assign pready_o        = s_reg.pready;
   assign prdata_o        = s_reg.prdata;
   assign pslverr_o       = 1'b0;
   assign loop_ready_o    = s_reg.ready;
   assign loop_value_o    = s_reg.val;
   assign mon_level_o     = s_reg.level;
   assign mon_active_o    = s_reg.mon_act;
   assign mon_sampled_o   = s_reg.mode;
   assign mon_sample_o    = s_reg.sample;
   assign mon_hysteresis_enable_o      = s_reg.hysteresis_enable;
   assign mon_reset_o     = s_reg.bod_reset;
   assign mon_irq_o       = s_reg.bod_irq;
   assign reg_high_drv_o  = s_reg.force_drv;
   assign reg_normal_o    = s_reg.reg_stby;
   assign bg_bandgap_calibration_o      = s_reg.bandgap_calibration;
   assign bg_route_o      = s_reg.bgout;
   assign ts_enable_o     = s_reg.temp_sensor_enable;
   assign pll_run_o       = s_reg.pll_run;
   assign mon_sync_busy_o = s_reg.busy;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   chk_ready_after_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr && paddr_i == `SSCR_OFF_SYNC && pwdata_i[`SSCR_B_VALUE_READ_REQUEST]) |=>
         !loop_ready_o ##1 !loop_ready_o ##1 loop_ready_o)
      else $error("loop ready not raised on time after request");
   chk_value_taken: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(loop_ready_o) |-> loop_value_o == $past(loop_live_i, 2))
      else $error("loop value not refreshed");
   chk_sync_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr && paddr_i == `SSCR_OFF_SUPMON) |=> mon_sync_busy_o [*4] ##1 !mon_sync_busy_o)
      else $error("monitor sync flag wrong length");
   chk_pll_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(s_reg.pll_stat) |-> $past(s_reg.pll_cnt) == 4'h1)
      else $error("pll status changed without delay");
   chk_pll_on_request_activation: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pll_run_o |-> $past(s_next.pll_onreq == 1'b0 || periph_req_i))
      else $error("pll runs without request");
   chk_bod_action: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mon_reset_o || mon_irq_o) |-> $past(supply_low_i) && $past(s_reg.action) != 2'h0)
      else $error("brown-out action without cause");
   chk_cen_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(s_reg.cen_run) |-> $past(s_reg.cen_cnt) == `SSCR_CEN_CYC)
      else $error("clock enable status changed early");
   chk_sample_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mon_sample_o |-> $past(s_reg.cen_run) && $past(s_reg.ulp_1k))
      else $error("sample strobe without enabled clock tick");

   // gating of the running outputs and start-up loading
   chk_mon_standby: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($past(standby_i) && !s_reg.mon_stby) |-> !mon_active_o)
      else $error("monitor active in standby without standby bit");
   chk_pll_standby: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($past(standby_i) && !s_reg.pll_stby) |-> !pll_run_o)
      else $error("pll runs in standby without standby bit");
   chk_pll_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !s_reg.pll_stat |-> !pll_run_o)
      else $error("pll runs before enabled status");
   chk_cen_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(s_reg.cen_run) |-> s_reg.cen_run == $past(s_reg.sampling_clock_enable))
      else $error("clock enable status moved away from written value");
   chk_bod_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !mon_active_o |=> !mon_reset_o && !mon_irq_o)
      else $error("brown-out action while monitor inactive");
   chk_row_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(start_load_i && !s_reg.loaded && !wr) |-> mon_level_o == $past(user_row_i[10:5]))
      else $error("threshold level not loaded from user row");
   chk_row_bandgap_calibration: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(start_load_i && !s_reg.loaded && !wr) |-> bg_bandgap_calibration_o == $past(bandgap_calibration_row_i))
      else $error("bandgap trim not loaded from calibration row");

endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench of the supply and clock control register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, start_load_i;
   logic        standby_i, supply_low_i, periph_req_i, pready_o, pslverr_o;
   logic        loop_ready_o, mon_active_o, mon_sampled_o, mon_sample_o, mon_hysteresis_enable_o;
   logic        mon_reset_o, mon_irq_o, reg_high_drv_o, reg_normal_o, bg_route_o;
   logic        ts_enable_o, pll_run_o, mon_sync_busy_o;
   logic [5:0]  mon_level_o;
   logic [10:0] user_row_i, bandgap_calibration_row_i, bg_bandgap_calibration_o, ur, cr;
   logic [11:0] paddr_i;
   logic [11:0] regs [4] = '{12'h034, 12'h03c, 12'h040, 12'h044};
   logic [31:0] pwdata_i, prdata_o, loop_live_i, loop_value_o, rd, d;
   logic [31:0] mdl [int];
   int          bad_count, total_checks, cycles, seed, i, j;

   sscr_top i_sscr_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .start_load_i(start_load_i), .user_row_i(user_row_i), .bandgap_calibration_row_i(bandgap_calibration_row_i),
      .loop_live_i(loop_live_i), .standby_i(standby_i), .supply_low_i(supply_low_i),
      .periph_req_i(periph_req_i), .loop_ready_o(loop_ready_o), .loop_value_o(loop_value_o),
      .mon_level_o(mon_level_o), .mon_active_o(mon_active_o), .mon_sampled_o(mon_sampled_o),
      .mon_sample_o(mon_sample_o), .mon_hysteresis_enable_o(mon_hysteresis_enable_o), .mon_reset_o(mon_reset_o),
      .mon_irq_o(mon_irq_o), .reg_high_drv_o(reg_high_drv_o), .reg_normal_o(reg_normal_o),
      .bg_bandgap_calibration_o(bg_bandgap_calibration_o), .bg_route_o(bg_route_o), .ts_enable_o(ts_enable_o),
      .pll_run_o(pll_run_o), .mon_sync_busy_o(mon_sync_busy_o));

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ceiling covers the sampled-mode wait of two 1kHz ticks, so only a hang trips it
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         test_done();
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // writable bits of each register; zero means no storage behind it
   function automatic logic [31:0] msk(input logic [11:0] a);
      case (a)
         12'h034: msk = 32'h003ff35e;
         12'h03c: msk = 32'h00002040;
         12'h040: msk = 32'h07ff0006;
         12'h044: msk = 32'h000000c2;
         default: msk = 32'h0;
      endcase
   endfunction

   // apb transfer: request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= dat;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (wr && msk(a) != 0)
         mdl[a] = dat & msk(a);
   endtask

   task automatic rdchk(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      chk(rd, (mdl.exists(a) && msk(a) != 0) ? mdl[a] : 32'h0);
   endtask

   // status bits settle late, so poll a bounded number of reads
   task automatic poll_stat(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h048, 32'h0);
         n++;
      end while (rd[b] !== v && n < 12);
      chk(rd[b], v);
   endtask

   task automatic outs;
      #1;
      chk(mon_level_o, mdl[12'h034][21:16]);
      chk({mon_sampled_o, mon_hysteresis_enable_o}, {mdl[12'h034][8], mdl[12'h034][2]});
      chk({reg_high_drv_o, reg_normal_o}, {mdl[12'h03c][13], mdl[12'h03c][6]});
      chk({bg_bandgap_calibration_o, bg_route_o, ts_enable_o}, {mdl[12'h040][26:16], mdl[12'h040][2:1]});
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 25;
      {rst_n_i, psel_i, penable_i, pwrite_i, start_load_i} = 5'h0;
      {standby_i, supply_low_i, periph_req_i} = 3'h0;
      {paddr_i, pwdata_i, user_row_i, bandgap_calibration_row_i, loop_live_i} = '0;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1 chk({pll_run_o, mon_active_o, loop_ready_o}, 32'h0);
      mdl[12'h044] = 32'h80;
      mdl[12'h03c] = 32'h0;
      rdchk(12'h044);
      // row data loads the monitor and trim fields once after reset
      ur = 11'($random(seed));
      cr = 11'($random(seed));
      @(posedge clk_i);
      user_row_i   <= ur;
      bandgap_calibration_row_i  <= cr;
      start_load_i <= 1'b1;
      @(posedge clk_i);
      start_load_i <= 1'b0;
      mdl[12'h034] = {10'h0, ur[10:5], 11'h0, ur[4:1], 1'b0};
      mdl[12'h040] = {5'h0, cr, 16'h0};
      repeat (6) @(posedge clk_i);
      rdchk(12'h034);
      rdchk(12'h040);
      outs();
      // random register traffic; monitor writes keep it disabled while level moves
      for (i = 0; i < 4; i++) begin
         for (j = 0; j < 4; j++) begin
            d = $random(seed);
            if (j == 0) begin
               d[1] = 1'b0;
               // level moves only while the monitor is already off
               if (mdl[12'h034][1])
                  d[21:16] = mdl[12'h034][21:16];
            end
            apb(1'b1, regs[j], d);
            if (j == 0)
               #1 chk(mon_sync_busy_o, 1'b1);
            repeat (6) @(posedge clk_i);
            #1 chk(mon_sync_busy_o, 1'b0);
            rdchk(regs[j]);
            outs();
         end
      end
      apb(1'b1, 12'h050, 32'hffffffff);
      chk(pslverr_o, 1'b0);
      rdchk(12'h050);
      rdchk(12'h030);
      // two read requests with different live values prove the refresh
      for (i = 0; i < 2; i++) begin
         @(posedge clk_i);
         loop_live_i <= $random(seed);
         apb(1'b1, 12'h030, 32'h80);
         chk(loop_ready_o, 1'b0);
         poll_stat(0, 1'b1);
         chk(loop_value_o, loop_live_i);
         chk(loop_ready_o, 1'b1);
      end
      // every defined action code with the monitor enabled and awake
      for (i = 0; i < 3; i++) begin
         d = (mdl[12'h034] & ~32'h0000005a) | 32'(i << 3) | 32'h2;
         apb(1'b1, 12'h034, d);
         repeat (6) @(posedge clk_i);
         supply_low_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         #1 chk({mon_reset_o, mon_irq_o}, {i == 1, i == 2});
         @(posedge clk_i);
         supply_low_i <= 1'b0;
      end
      @(posedge clk_i);
      standby_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 chk(mon_active_o, 1'b0);
      apb(1'b1, 12'h034, mdl[12'h034] | 32'h40);
      repeat (6) @(posedge clk_i);
      #1 chk(mon_active_o, 1'b1);
      // loop: always-on, standby gating, then on-request gating
      @(posedge clk_i);
      standby_i <= 1'b0;
      apb(1'b1, 12'h044, 32'h02);
      poll_stat(2, 1'b1);
      repeat (2) @(posedge clk_i);
      #1 chk(pll_run_o, 1'b1);
      @(posedge clk_i);
      standby_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 chk(pll_run_o, 1'b0);
      apb(1'b1, 12'h044, 32'hc2);
      repeat (3) @(posedge clk_i);
      #1 chk(pll_run_o, 1'b0);
      @(posedge clk_i);
      periph_req_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 chk(pll_run_o, 1'b1);
      apb(1'b1, 12'h044, 32'h80);
      poll_stat(2, 1'b0);
      repeat (2) @(posedge clk_i);
      #1 chk(pll_run_o, 1'b0);
      // sampled mode at divide-by-2: a strobe within two 1kHz ticks of 24992 cycles
      apb(1'b1, 12'h034, (mdl[12'h034] & ~32'h0000f000) | 32'h00000300);
      i = 0;
      while (mon_sample_o !== 1'b1 && i < 52000) begin
         @(posedge clk_i);
         i++;
      end
      chk(mon_sample_o, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
